// ---- common/pjss_pkg.sv ----
// package: constants and register map of the programmable jk state sequencer
package pjss_pkg;
  localparam int NUM_TERMS  = 48;
  localparam int NUM_INPUTS = 16;
  localparam int NUM_STATE  = 6;
  localparam int NUM_OUT    = 8;
  localparam int NUM_VARS   = 23;       // inputs, state bits, complement
  localparam int NUM_JK     = 14;       // state bits then output bits
  localparam int VAR_STATE_LSB = 16;
  localparam int VAR_COMP      = 22;
  // register map
  localparam logic [11:0] TERM_BASE_ADDR = 12'h000;   // 16 bytes per term
  localparam logic [1:0]  TERM_TRUE_SUB  = 2'h0;
  localparam logic [1:0]  TERM_FALSE_SUB = 2'h1;
  localparam logic [1:0]  TERM_ORJK_SUB  = 2'h2;
  localparam logic [11:0] COMP_LO_ADDR   = 12'h300;
  localparam logic [11:0] COMP_HI_ADDR   = 12'h304;
  localparam logic [11:0] CTRL_ADDR      = 12'h308;
  localparam logic [11:0] STATUS_ADDR    = 12'h30c;
  // field positions
  localparam int ORJK_J_LSB     = 0;
  localparam int ORJK_K_LSB     = 16;
  localparam int CTRL_MODE_BIT  = 0;    // 1 = preset, 0 = output enable
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_OUT_LSB   = 8;
  localparam int STAT_LOCK_BIT  = 16;
  // reset values
  localparam logic        CTRL_MODE_RST = 1'b1;
  localparam logic [22:0] MASK_RST      = 23'h000000;
  localparam logic [7:0]  PINS_RST      = 8'hff;
endpackage

// ---- logic/pjss_jk_bank.sv ----
// module: a bank of j-k flip-flops with preset, parallel load and hold
`timescale 1ns/1ps
module pjss_jk_bank
  import pjss_pkg::*;
#(
  parameter int W = 6
)(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // controls
  input  wire logic         set_all,
  input  wire logic         load_en,
  input  wire logic [W-1:0] load_val,
  input  wire logic         run,
  input  wire logic [W-1:0] j,
  input  wire logic [W-1:0] k,
  // state
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] q;
  } pjss_bank_type;

  pjss_bank_type st_r;
  pjss_bank_type st_nxt;

  // preset wins, then load, then the j-k update; otherwise hold
  always_comb
  begin
    st_nxt = st_r;
    if (set_all)
      st_nxt.q = '1;
    else if (load_en)
      st_nxt.q = load_val;
    else if (run)
      st_nxt.q = (j & ~st_r.q) | (~k & st_r.q);
  end

  // power-up leaves every bit at one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r.q <= '1;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_jk_toggle: assert property (
    (run && !set_all && !load_en && j[0] && k[0]) |=> (q[0] != $past(q[0])))
    else $error("j-k bit did not toggle");
  a_jk_hold: assert property (
    (!run && !set_all && !load_en) |=> $stable(q))
    else $error("j-k bank changed without a clock update");
endmodule // pjss_jk_bank

// ---- logic/pjss_core.sv ----
// module: programmable jk state sequencer with apb configuration
`timescale 1ns/1ps
module pjss_core
  import pjss_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // logic inputs and diagnostic mode selects
  input  wire logic [15:0] logic_inputs,
  input  wire logic        output_load_diag_input,
  input  wire logic        state_load_diag_input,
  input  wire logic        state_observe_diag_input,
  // shared preset or output enable pin
  input  wire logic        preset_or_output_enable,
  // output pins, three-signal form
  input  wire logic [7:0]  output_pins_in,
  output logic      [7:0]  output_pins_out,
  output logic      [7:0]  output_pins_oe
);
  typedef struct packed {
    logic [NUM_TERMS-1:0][NUM_VARS-1:0] and_true;
    logic [NUM_TERMS-1:0][NUM_VARS-1:0] and_false;
    logic [NUM_TERMS-1:0][NUM_JK-1:0]   or_j;
    logic [NUM_TERMS-1:0][NUM_JK-1:0]   or_k;
    logic [NUM_TERMS-1:0]               comp_sel;
    logic                               preset_mode;
    logic                               lockout;
    logic [7:0]                         pin_out;
    logic [7:0]                         pin_oe;
    logic [31:0]                        prdata;
    logic                               pready;
    logic                               pslverr;
  } pjss_core_type;

  pjss_core_type st_r;
  pjss_core_type st_nxt;

  logic [NUM_STATE-1:0] buried_state_bits;
  logic [NUM_OUT-1:0]   output_register_bits;
  logic [NUM_TERMS-1:0] pass1_term;
  logic [NUM_TERMS-1:0] transition_term;
  logic                 complement_array_output;
  logic [NUM_JK-1:0]    j_all;
  logic [NUM_JK-1:0]    k_all;
  logic [NUM_VARS-1:0]  vars;
  logic                 async_preset;
  logic                 any_load;
  logic                 run;
  logic                 setup_ph;
  logic                 wr_fire;
  logic                 addr_hit;
  logic [5:0]           term_idx;
  logic [1:0]           term_sub;
  logic [31:0]          rd_word;

  // the shared pin acts as preset only in preset mode
  assign async_preset = st_r.preset_mode & preset_or_output_enable;
  assign any_load     = output_load_diag_input | state_load_diag_input;
  // clocking is inhibited under preset and for the edge after it
  assign run          = ~async_preset & ~st_r.lockout;

  // term evaluation; the complement variable is masked in a first pass
  // so the feedback is not a combinational loop; terms that feed the
  // complement must therefore not themselves use it
  always_comb
  begin
    vars = {1'b0, buried_state_bits, logic_inputs};
    for (int t = 0; t < NUM_TERMS; t++)
    begin
      pass1_term[t] = &((~st_r.and_true[t] | vars) &
                        (~st_r.and_false[t] | ~vars) |
                        (NUM_VARS'(1) << VAR_COMP));
    end
    complement_array_output = ~|(pass1_term & st_r.comp_sel);
    vars[VAR_COMP] = complement_array_output;
    j_all = '0;
    k_all = '0;
    for (int t = 0; t < NUM_TERMS; t++)
    begin
      transition_term[t] = &((~st_r.and_true[t] | vars) &
                             (~st_r.and_false[t] | ~vars));
      if (transition_term[t])
      begin
        j_all = j_all | st_r.or_j[t];
        k_all = k_all | st_r.or_k[t];
      end
    end
  end

  // state register: buried, loadable from pins 0-5 in diagnostics
  pjss_jk_bank #(.W(NUM_STATE)) u_state (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_all  (async_preset),
    .load_en  (run & state_load_diag_input & ~output_load_diag_input),
    .load_val (output_pins_in[NUM_STATE-1:0]),
    .run      (run & ~any_load),
    .j        (j_all[NUM_STATE-1:0]),
    .k        (k_all[NUM_STATE-1:0]),
    .q        (buried_state_bits)
  );

  // output register: loadable from all pins in diagnostics
  pjss_jk_bank #(.W(NUM_OUT)) u_output (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_all  (async_preset),
    .load_en  (run & output_load_diag_input),
    .load_val (output_pins_in),
    .run      (run & ~any_load),
    .j        (j_all[NUM_JK-1:NUM_STATE]),
    .k        (k_all[NUM_JK-1:NUM_STATE]),
    .q        (output_register_bits)
  );

  // apb decode: two-cycle transfer, answer registered in the setup cycle
  always_comb
  begin
    setup_ph = psel & ~penable;
    wr_fire  = psel & penable & st_r.pready & pwrite;
    term_idx = paddr[9:4];
    term_sub = paddr[3:2];
    addr_hit = 1'b0;
    rd_word  = '0;
    if (paddr[1:0] == 2'h0)
    begin
      if (paddr < COMP_LO_ADDR)
      begin
        addr_hit = (term_sub != 2'h3);
        case (term_sub)
          TERM_TRUE_SUB:  rd_word[NUM_VARS-1:0] = st_r.and_true[term_idx];
          TERM_FALSE_SUB: rd_word[NUM_VARS-1:0] = st_r.and_false[term_idx];
          TERM_ORJK_SUB:
          begin
            rd_word[ORJK_J_LSB +: NUM_JK] = st_r.or_j[term_idx];
            rd_word[ORJK_K_LSB +: NUM_JK] = st_r.or_k[term_idx];
          end
          default:        rd_word = '0;
        endcase
      end
      else
      begin
        addr_hit = 1'b1;
        case (paddr)
          COMP_LO_ADDR: rd_word = st_r.comp_sel[31:0];
          COMP_HI_ADDR: rd_word[15:0] = st_r.comp_sel[47:32];
          CTRL_ADDR:    rd_word[CTRL_MODE_BIT] = st_r.preset_mode;
          STATUS_ADDR:
          begin
            rd_word[STAT_STATE_LSB +: NUM_STATE] = buried_state_bits;
            rd_word[STAT_OUT_LSB +: NUM_OUT]     = output_register_bits;
            rd_word[STAT_LOCK_BIT]               = st_r.lockout;
          end
          default:      addr_hit = 1'b0;
        endcase
      end
    end
  end

  // next state: configuration writes, lockout and pin drivers
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pready  = setup_ph;
    st_nxt.pslverr = setup_ph & ~addr_hit;
    st_nxt.prdata  = (setup_ph & ~pwrite) ? rd_word : '0;
    // configuration is written beforehand and held static while running
    if (wr_fire && addr_hit)
    begin
      if (paddr < COMP_LO_ADDR)
      begin
        case (term_sub)
          TERM_TRUE_SUB:  st_nxt.and_true[term_idx]  = pwdata[NUM_VARS-1:0];
          TERM_FALSE_SUB: st_nxt.and_false[term_idx] = pwdata[NUM_VARS-1:0];
          TERM_ORJK_SUB:
          begin
            st_nxt.or_j[term_idx] = pwdata[ORJK_J_LSB +: NUM_JK];
            st_nxt.or_k[term_idx] = pwdata[ORJK_K_LSB +: NUM_JK];
          end
          default:        st_nxt.or_j[term_idx] = st_r.or_j[term_idx];
        endcase
      end
      else
      begin
        case (paddr)
          COMP_LO_ADDR: st_nxt.comp_sel[31:0]  = pwdata;
          COMP_HI_ADDR: st_nxt.comp_sel[47:32] = pwdata[15:0];
          CTRL_ADDR:    st_nxt.preset_mode     = pwdata[CTRL_MODE_BIT];
          default:      st_nxt.preset_mode     = st_r.preset_mode;
        endcase
      end
    end
    // the first edge after preset release is swallowed
    st_nxt.lockout = async_preset;
    // pin drivers; registered, so pins follow the registers one cycle late
    if (async_preset)
    begin
      st_nxt.pin_out = PINS_RST;
      st_nxt.pin_oe  = '1;
    end
    else
    begin
      if (state_observe_diag_input)
        st_nxt.pin_out = {output_register_bits[7:6], buried_state_bits};
      else
        st_nxt.pin_out = output_register_bits;
      if (any_load)
        st_nxt.pin_oe = '0;
      else if (!st_r.preset_mode && preset_or_output_enable)
        st_nxt.pin_oe = '0;
      else
        st_nxt.pin_oe = '1;
    end
  end

  // register the whole state; power-up selects preset mode like a blank part
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r             <= '0;
      st_r.and_true    <= {NUM_TERMS{MASK_RST}};
      st_r.and_false   <= {NUM_TERMS{MASK_RST}};
      st_r.preset_mode <= CTRL_MODE_RST;
      st_r.pin_out     <= PINS_RST;
      st_r.pin_oe      <= '1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata          = st_r.prdata;
  assign pready          = st_r.pready;
  assign pslverr         = st_r.pslverr;
  assign output_pins_out = st_r.pin_out;
  assign output_pins_oe  = st_r.pin_oe;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // preset wins over everything; the registered pins follow one edge later
  a_preset_sets_all: assert property (
    async_preset |=> (buried_state_bits == '1) && (output_register_bits == '1)
                     ##1 (output_pins_out == PINS_RST))
    else $error("preset did not set registers and pins high");
  // the swallowed edge must move neither register
  a_lockout_edge: assert property (
    (st_r.lockout && !async_preset) |=>
      $stable(buried_state_bits) && $stable(output_register_bits))
    else $error("edge after preset release was not ignored");
  // disabled drivers must not stop the registers or the value behind the pins
  a_oe_floats: assert property (
    (!st_r.preset_mode && preset_or_output_enable && !state_observe_diag_input)
      |=> (output_pins_oe == '0)
          && (output_pins_out == $past(output_register_bits)))
    else $error("output enable high did not float pins");
  // load modes take the pins and leave the other register alone
  a_state_load: assert property (
    (run && state_load_diag_input && !output_load_diag_input) |=>
      (buried_state_bits == $past(output_pins_in[5:0]))
      && $stable(output_register_bits))
    else $error("state load mode did not load pins 0-5");
  a_output_load: assert property (
    (run && output_load_diag_input && !state_load_diag_input) |=>
      (output_register_bits == $past(output_pins_in))
      && $stable(buried_state_bits))
    else $error("output load mode did not load the pins");
  a_load_hiz: assert property (
    (any_load && !async_preset) |=> (output_pins_oe == '0))
    else $error("pin drivers on during a load mode");
  a_observe_pins: assert property (
    (state_observe_diag_input && !any_load && !async_preset) |=>
      (output_pins_out[5:0] == $past(buried_state_bits)))
    else $error("observe mode does not show the state register");
  a_apb_answer: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not exactly one access cycle");

  // pins follow the output register one edge late outside observe and preset
  a_pins_follow: assert property (
    (!state_observe_diag_input && !async_preset) |=>
      (output_pins_out == $past(output_register_bits)))
    else $error("output pins do not follow the output register");
  // in enable mode a low pin drives every pin outside the load modes and the pin never presets
  a_oe_drives: assert property (
    (!st_r.preset_mode && !preset_or_output_enable && !any_load) |=>
      (output_pins_oe == '1))
    else $error("output enable low did not drive the pins");
  a_no_preset_in_oe: assert property (
    (!st_r.preset_mode && preset_or_output_enable) |=> !st_r.lockout)
    else $error("shared pin preset the registers in enable mode");
  // a refused address answers with an error in the same single access cycle
  a_apb_error: assert property (
    (psel && !penable && (paddr[1:0] != 2'h0)) |=> (pready && pslverr))
    else $error("unaligned access was not refused");
endmodule // pjss_core

// ---- testbench/pjss_far_side.sv ----
// far-side model: resolves the output pins and drives them in the load modes
`timescale 1ns/1ps
module pjss_far_side
(
  // clock
  input  wire logic       pclk,
  // bench control of the outside drivers
  input  wire logic       drv_en,
  input  wire logic [7:0] drv_val,
  // device side of the pins
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_lvl
);
  logic [7:0] last_r;

  // a bit nobody drives shows the inverse of its last level, so stale data never passes
  always_comb
  begin
    for (int b = 0; b < 8; b++)
      pin_lvl[b] = pin_oe[b] ? pin_out[b] : (drv_en ? drv_val[b] : ~last_r[b]);
  end

  // level history for floating bits
  always_ff @(posedge pclk)
    last_r <= pin_lvl;
endmodule // pjss_far_side

// ---- testbench/tb_top.sv ----
// testbench: apb access and sequencer scenarios with queued expectations
`timescale 1ns/1ps
module tb_top;
  import pjss_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        oload, sload, sobs, pre_oe, drv_en, lock;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [15:0] lin;
  logic [13:0] m;
  logic [7:0]  pin_lvl, pin_out, pin_oe, drv_val;
  int          error_cnt, n_checks, pin_on;
  logic [32:0] apb_q[$];
  logic [31:0] pin_q[$];
  logic [31:0] pin_note;

  pjss_core DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .logic_inputs(lin),
    .output_load_diag_input(oload), .state_load_diag_input(sload),
    .state_observe_diag_input(sobs), .preset_or_output_enable(pre_oe),
    .output_pins_in(pin_lvl), .output_pins_out(pin_out), .output_pins_oe(pin_oe));
  pjss_far_side far (.pclk(pclk), .drv_en(drv_en), .drv_val(drv_val),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl));

  // clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function logic [15:0] next_rnd;
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd[15:0];
  endfunction

  // reference of the programmed terms: t0 needs x0, t1 needs !x0 x1 !s0, t2 the else
  function automatic logic [13:0] jk(input logic [13:0] q, input logic [15:0] x);
    logic        t0, t1, t2;
    logic [13:0] j, k;
    t0 = x[0];
    t1 = !x[0] && x[1] && !q[0];
    t2 = !(t0 || t1);
    j = {7'h0, t0, 5'h0, t0};
    k = {6'h0, t1, t0, 5'h0, t2};
    return (j & ~q) | (~k & q);
  endfunction

  // one apb transfer; the expected {pslverr, prdata} is queued for the monitor
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    apb_q.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // idle edge: the next call raises psel without a second assignment
  endtask

  // mode: 0 run, 1 observe, 2 state load, 3 output load, 4 preset, 5 drivers off
  task automatic run(input int mode, input int len, input logic rn, input logic [7:0] pv);
    logic [15:0] x, care;
    logic [7:0]  po, oe;
    for (int i = 0; i < len; i++)
    begin
      x = rn ? next_rnd() : 16'h0;
      lin <= x;
      oload <= (mode == 3);
      sload <= (mode == 2);
      sobs <= (mode == 1);
      pre_oe <= (mode >= 4);
      drv_en <= (mode == 2 || mode == 3);
      drv_val <= pv;
      if (mode == 4)
      begin
        m = 14'h3fff;
        lock = 1'b1;
      end
      else if (lock)
        lock = 1'b0;
      else if (mode == 3)
        m[13:6] = pv;
      else if (mode == 2)
        m[5:0] = pv[5:0];
      else
        m = jk(m, x);
      po = (mode == 1) ? {m[13:12], m[5:0]} : m[13:6];
      oe = (mode == 2) ? 8'hc0 : (mode == 3 || mode == 5) ? 8'h00 : 8'hff;
      care = (mode == 2) ? 16'h3f00 : (mode == 3 || mode == 5) ? 16'hff00 : 16'hffff;
      if (i == len - 1)
        care = 16'h0;
      pin_q.push_back({care, oe, po});
      @(posedge pclk);
    end
  endtask

  // apb monitor: takes the oldest note when a transfer completes
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
      check({pslverr, prdata}, apb_q.pop_front());

  // pin monitor: a note is due two edges after it was queued
  // both sides are masked by the same care bits
  always @(negedge pclk)
    if (pin_on && pin_q.size() >= 3)
    begin
      pin_note = pin_q.pop_front();
      check(33'({pin_oe, pin_out} & pin_note[31:16]), 33'(pin_note[15:0] & pin_note[31:16]));
    end

  // watchdog
  initial
  begin
    repeat (4000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, oload, sload, sobs, pre_oe, drv_en, lock} = '0;
    {paddr, pwdata, lin, drv_val} = '0;
    rnd = 32'h19;
    m = 14'h3fff;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, STATUS_ADDR, 32'h0, 33'h0000ff3f);
    apb(1'b0, CTRL_ADDR, 32'h0, 33'h1);
    apb(1'b0, 12'h00c, 32'h0, 33'h100000000);
    apb(1'b0, 12'h002, 32'h0, 33'h100000000);
    apb(1'b1, 12'h000, 32'h1, 33'h0);
    apb(1'b1, 12'h010, 32'h2, 33'h0);
    apb(1'b1, 12'h014, 32'h10001, 33'h0);
    apb(1'b1, 12'h020, 32'h400000, 33'h0);
    apb(1'b1, COMP_LO_ADDR, 32'h3, 33'h0);
    apb(1'b1, 12'h008, 32'h400041, 33'h0);
    apb(1'b1, 12'h018, 32'h800000, 33'h0);
    apb(1'b1, 12'h028, 32'h10000, 33'h0);
    apb(1'b0, 12'h014, 32'h0, 33'h10001);
    m = jk(m, 16'h0);
    pin_on = 1;
    run(0, 40, 1'b1, 8'h0);
    run(0, 4, 1'b0, 8'h0);
    run(1, 5, 1'b0, 8'h0);
    run(2, 5, 1'b0, 8'h15);
    run(1, 4, 1'b0, 8'h0);
    run(0, 4, 1'b0, 8'h0);
    run(3, 5, 1'b0, 8'ha6);
    run(0, 10, 1'b1, 8'h0);
    run(4, 3, 1'b0, 8'h0);
    run(0, 10, 1'b1, 8'h0);
    run(0, 4, 1'b0, 8'h0);
    pin_on = 0;
    pin_q.delete();
    apb(1'b1, CTRL_ADDR, 32'h0, 33'h0);
    pin_on = 1;
    run(5, 6, 1'b1, 8'h0);
    run(0, 10, 1'b1, 8'h0);
    run(0, 3, 1'b0, 8'h0);
    stop_test();
  end
endmodule // tb_top
